/* File: inc/swr_pkg.sv */
// Shared constants and types for the single-wire slave ROM layer.
// Assumes a 40 MHz system clock; all times are converted to cycles here.
package swr_pkg;

  // ********************************************************************
  // Clock and timing
  // ********************************************************************
  localparam int unsigned CLK_PERIOD_PS = 25000;
  // Slave sampling point of a write slot (least time, rounded up)
  localparam int unsigned STD_SAMPLE_NS = 30000;
  localparam int unsigned OD_SAMPLE_NS = 3000;
  // Read-zero pulldown end (longest time, rounded down)
  localparam int unsigned STD_READ_LOW_NS = 45000;
  localparam int unsigned OD_READ_LOW_NS = 6000;
  // Rising edge hold-off window
  localparam int unsigned STD_HOLDOFF_NS = 5000;
  localparam int unsigned OD_HOLDOFF_NS = 1000;
  // Presence high delay and presence low duration
  localparam int unsigned STD_PDH_NS = 30000;
  localparam int unsigned OD_PDH_NS = 3000;
  localparam int unsigned STD_PDL_NS = 120000;
  localparam int unsigned OD_PDL_NS = 12000;
  // Reset low time: detection thresholds and long reset
  localparam int unsigned STD_RESET_NS = 480000;
  localparam int unsigned OD_RESET_NS = 48000;
  localparam int unsigned LONG_RESET_NS = 480000;

  localparam int unsigned CNT_W = 16;
  localparam logic [15:0] STD_SAMPLE_CYC =
    16'((STD_SAMPLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [15:0] OD_SAMPLE_CYC =
    16'((OD_SAMPLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [15:0] STD_READ_LOW_CYC = 16'((STD_READ_LOW_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [15:0] OD_READ_LOW_CYC = 16'((OD_READ_LOW_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [15:0] STD_HOLDOFF_CYC =
    16'((STD_HOLDOFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [15:0] OD_HOLDOFF_CYC =
    16'((OD_HOLDOFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [15:0] STD_PDH_CYC =
    16'((STD_PDH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [15:0] OD_PDH_CYC =
    16'((OD_PDH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned STD_PDL_CYC = (STD_PDL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [15:0] OD_PDL_CYC =
    16'((OD_PDL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned STD_RESET_CYC =
    (STD_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [15:0] OD_RESET_CYC =
    16'((OD_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned LONG_RESET_CYC =
    (LONG_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ********************************************************************
  // ROM commands
  // ********************************************************************
  localparam logic [7:0] CMD_READ_ROM = 8'h33;
  localparam logic [7:0] CMD_MATCH_ROM = 8'h55;
  localparam logic [7:0] CMD_SEARCH_ROM = 8'hf0;
  localparam logic [7:0] CMD_SKIP_ROM = 8'hcc;
  localparam logic [7:0] CMD_RESUME = 8'ha5;
  localparam logic [7:0] CMD_OD_SKIP_ROM = 8'h3c;
  localparam logic [7:0] CMD_OD_MATCH_ROM = 8'h69;
  localparam logic [5:0] LAST_ID_BIT = 6'h3f;
  localparam logic [5:0] LAST_CMD_BIT = 6'h07;
  localparam int unsigned FIFO_DEPTH = 4;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [2:0] {
    SL_IDLE = 3'h0,
    SL_LOW = 3'h1,
    SL_HOLD = 3'h3,
    SL_RST = 3'h2,
    SL_PDH = 3'h6,
    SL_PDL = 3'h7
  } swr_slot_e;

  typedef enum logic [3:0] {
    RM_IDLE = 4'h0,
    RM_CMD = 4'h1,
    RM_MATCH = 4'h3,
    RM_FUNC = 4'h2,
    RM_READ = 4'h6,
    RM_STRUE = 4'h7,
    RM_SCMP = 4'h5,
    RM_SDIR = 4'h4,
    RM_DEAD = 4'hc
  } swr_rom_e;

  // Completed slot: one-cycle valid with sampled line level
  typedef struct packed {
    logic valid;
    logic value;
  } swr_bit_s;

  // Completed reset pulse: valid and whether it was a long one
  typedef struct packed {
    logic valid;
    logic long_pulse;
  } swr_rst_s;

endpackage

/* File: hw/swr_slave.sv */
// Slot engine, ROM command layer and function-byte FIFO of a single-wire slave.
// Assumes the bus level arrives synchronous to clk_sys_i; the pad resolves
// the open-drain wire from bus_oe_o.
`timescale 1ns/1ps

// ********************************************************************
// Function byte FIFO, head entry held in a flip-flop
// ********************************************************************
module swr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [CW-1:0] count_r, count_nxt, wr_pos;
  logic valid_r, valid_nxt, push, pop;

  assign in_ready_o = (count_r != CW'(DEPTH));
  assign push = in_valid_i && in_ready_o;
  assign pop = valid_r && out_ready_i;
  assign out_valid_o = valid_r;
  assign out_data_o = mem_r[0];

  always_comb begin
    wr_pos = pop ? count_r - CW'(1) : count_r;
    count_nxt = count_r + CW'(push) - CW'(pop);
    valid_nxt = (count_nxt != '0);
  end

  for (genvar k = 0; k < DEPTH; k++) begin : g_entry
    always_comb begin
      if (push && wr_pos == CW'(k)) begin
        mem_nxt[k] = in_data_i;
      end else if (pop && k < DEPTH - 1) begin
        mem_nxt[k] = mem_r[(k + 1) % DEPTH];
      end else begin
        mem_nxt[k] = mem_r[k];
      end
    end
    always_ff @(posedge clk_sys_i) begin
      mem_r[k] <= mem_nxt[k];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      count_r <= '0;
      valid_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      valid_r <= valid_nxt;
    end
  end
endmodule // swr_fifo

// Overview of operation
// - Every bus slot carries one bit; write slots in, read slots out.
// - Each master falling edge in idle starts the slot timer for sample and pulldown.
// - Read zero: slave pulls low and releases when its slot timer expires.
// - Read one: slave never drives the line.
// - After presence, accept one eight-bit ROM command; seven exist.
// - Read ROM sends the 64-bit identifier.
// - Match ROM compares 64 bits; mismatch idles until next reset.
// - Search ROM: true bit, complement, master bit; leave on difference.
// - Skip ROM goes straight to function commands.
// - Resume goes to function commands only if resume flag set.
// - Resume flag set only by successful match, search or overdrive match.
// - Resume flag cleared when another device is addressed.
// - Overdrive skip sets overdrive flag and goes to function commands.
// - Overdrive match receives at fast speed; restores the previous speed on mismatch.
// - Lows inside the hold-off after a rise are ignored; later lows start slots.
// - Long reset clears overdrive; short overdrive reset keeps it.
// - After reset release, wait presence high delay, then pull low.
module swr_slave
  import swr_pkg::*;
#(
  parameter logic [63:0] ROM_ID = 64'h5a00_0000_0000_0128, // Arbitrary value
  parameter int unsigned RST_STD_CYC = STD_RESET_CYC,
  parameter int unsigned RST_LONG_CYC = LONG_RESET_CYC,
  parameter int unsigned PDL_CYC = STD_PDL_CYC,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic bus_in_i,
  output logic bus_out_o,
  output logic bus_oe_o,
  output logic fn_valid_o,
  input wire logic fn_ready_i,
  output logic [7:0] fn_data_o,
  output logic selected_o,
  output logic overdrive_flag_o,
  output logic resume_flag_o
);

  // ********************************************************************
  // Slot engine
  // ********************************************************************
  swr_slot_e sl_r, sl_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic drv_r, drv_nxt;
  swr_bit_s ev_r, ev_nxt;
  swr_rst_s rst_r, rst_nxt;
  logic [15:0] t_samp, t_rlow, t_hold, t_pdh, t_pdl, t_rst;
  logic od_r, tx_en_r, tx_bit_r, stall;

  always_comb begin
    t_samp = od_r ? OD_SAMPLE_CYC : STD_SAMPLE_CYC;
    t_rlow = od_r ? OD_READ_LOW_CYC : STD_READ_LOW_CYC;
    t_hold = od_r ? OD_HOLDOFF_CYC : STD_HOLDOFF_CYC;
    t_pdh = od_r ? OD_PDH_CYC : STD_PDH_CYC;
    t_pdl = od_r ? OD_PDL_CYC : 16'(PDL_CYC);
    t_rst = od_r ? OD_RESET_CYC : 16'(RST_STD_CYC);
    sl_nxt = sl_r;
    cnt_nxt = (cnt_r == 16'hffff) ? cnt_r : cnt_r + 16'h1;
    drv_nxt = drv_r;
    ev_nxt = '0;
    rst_nxt = '0;
    unique case (sl_r)
      SL_IDLE: begin
        if (!bus_in_i) begin
          sl_nxt = SL_LOW;
          cnt_nxt = 16'h0;
          drv_nxt = tx_en_r && !tx_bit_r && !stall;
        end
      end
      SL_LOW: begin
        if (cnt_r == t_samp) begin
          ev_nxt.valid = 1'b1;
          ev_nxt.value = bus_in_i;
        end
        if (cnt_r == t_rlow) begin
          drv_nxt = 1'b0;
        end
        if (bus_in_i && cnt_r > t_samp) begin
          sl_nxt = SL_HOLD;
          cnt_nxt = 16'h0;
        end else if (!bus_in_i && cnt_r >= t_rst) begin
          sl_nxt = SL_RST;
        end
      end
      SL_RST: begin
        if (bus_in_i) begin
          sl_nxt = SL_PDH;
          cnt_nxt = 16'h0;
          rst_nxt.valid = 1'b1;
          rst_nxt.long_pulse = (cnt_r >= 16'(RST_LONG_CYC));
        end
      end
      SL_PDH: begin
        if (cnt_r == t_pdh) begin
          sl_nxt = SL_PDL;
          drv_nxt = 1'b1;
          cnt_nxt = 16'h0;
        end
      end
      SL_PDL: begin
        if (cnt_r == t_pdl) begin
          sl_nxt = SL_HOLD;
          drv_nxt = 1'b0;
          cnt_nxt = 16'h0;
        end
      end
      SL_HOLD: begin
        if (cnt_r == t_hold) begin
          sl_nxt = SL_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sl_r <= SL_IDLE;
      cnt_r <= 16'h0;
      drv_r <= 1'b0;
      ev_r <= '0;
      rst_r <= '0;
    end else begin
      sl_r <= sl_nxt;
      cnt_r <= cnt_nxt;
      drv_r <= drv_nxt;
      ev_r <= ev_nxt;
      rst_r <= rst_nxt;
    end
  end

  assign bus_out_o = 1'b0;
  assign bus_oe_o = drv_r;

  // ********************************************************************
  // ROM command layer
  // ********************************************************************
  swr_rom_e rs_r, rs_nxt;
  logic [5:0] idx_r, idx_nxt, idx_p1;
  logic [7:0] sh_r, sh_nxt, cmd;
  logic od_nxt, odb_r, odb_nxt, odm_r, odm_nxt, rc_r, rc_nxt;
  logic tx_en_nxt, tx_bit_nxt, pend_r, pend_nxt, sel_r, sel_nxt, f_ready;

  assign idx_p1 = idx_r + 6'h1;
  assign cmd = {ev_r.value, sh_r[7:1]};
  assign stall = pend_r;

  always_comb begin
    rs_nxt = rs_r;
    idx_nxt = idx_r;
    sh_nxt = sh_r;
    od_nxt = od_r;
    odb_nxt = odb_r;
    odm_nxt = odm_r;
    rc_nxt = rc_r;
    tx_en_nxt = tx_en_r;
    tx_bit_nxt = tx_bit_r;
    pend_nxt = pend_r && !f_ready;
    if (rst_r.valid) begin
      rs_nxt = RM_CMD;
      idx_nxt = 6'h0;
      tx_en_nxt = 1'b0;
      if (rst_r.long_pulse) begin
        od_nxt = 1'b0;
      end
    end else if (ev_r.valid) begin
      unique case (rs_r)
        RM_CMD: begin
          sh_nxt = cmd;
          idx_nxt = idx_p1;
          if (idx_r == LAST_CMD_BIT) begin
            idx_nxt = 6'h0;
            odm_nxt = 1'b0;
            if (cmd == CMD_READ_ROM) begin
              rs_nxt = RM_READ;
              tx_en_nxt = 1'b1;
              tx_bit_nxt = ROM_ID[0];
            end else if (cmd == CMD_MATCH_ROM) begin
              rs_nxt = RM_MATCH;
            end else if (cmd == CMD_SEARCH_ROM) begin
              rs_nxt = RM_STRUE;
              tx_en_nxt = 1'b1;
              tx_bit_nxt = ROM_ID[0];
            end else if (cmd == CMD_SKIP_ROM) begin
              rs_nxt = RM_FUNC;
            end else if (cmd == CMD_RESUME) begin
              rs_nxt = rc_r ? RM_FUNC : RM_DEAD;
            end else if (cmd == CMD_OD_SKIP_ROM) begin
              od_nxt = 1'b1;
              rs_nxt = RM_FUNC;
            end else if (cmd == CMD_OD_MATCH_ROM) begin
              odb_nxt = od_r;
              od_nxt = 1'b1;
              odm_nxt = 1'b1;
              rs_nxt = RM_MATCH;
            end else begin
              rs_nxt = RM_DEAD;
            end
          end
        end
        RM_READ: begin
          idx_nxt = idx_p1;
          tx_bit_nxt = ROM_ID[idx_p1];
          if (idx_r == LAST_ID_BIT) begin
            rs_nxt = RM_FUNC;
            tx_en_nxt = 1'b0;
          end
        end
        RM_MATCH: begin
          idx_nxt = idx_p1;
          if (ev_r.value != ROM_ID[idx_r]) begin
            rs_nxt = RM_DEAD;
            rc_nxt = 1'b0;
            od_nxt = odm_r ? odb_r : od_r;
          end else if (idx_r == LAST_ID_BIT) begin
            rs_nxt = RM_FUNC;
            rc_nxt = 1'b1;
          end
        end
        RM_STRUE: begin
          tx_bit_nxt = !ROM_ID[idx_r];
          rs_nxt = RM_SCMP;
        end
        RM_SCMP: begin
          tx_en_nxt = 1'b0;
          rs_nxt = RM_SDIR;
        end
        RM_SDIR: begin
          if (ev_r.value != ROM_ID[idx_r]) begin
            rs_nxt = RM_DEAD;
            rc_nxt = 1'b0;
          end else if (idx_r == LAST_ID_BIT) begin
            rs_nxt = RM_FUNC;
            idx_nxt = 6'h0;
            rc_nxt = 1'b1;
          end else begin
            idx_nxt = idx_p1;
            tx_en_nxt = 1'b1;
            tx_bit_nxt = ROM_ID[idx_p1];
            rs_nxt = RM_STRUE;
          end
        end
        RM_FUNC: begin
          if (!pend_r) begin
            sh_nxt = cmd;
            idx_nxt = {3'h0, idx_p1[2:0]};
            pend_nxt = (idx_r[2:0] == 3'h7);
          end
        end
        RM_IDLE, RM_DEAD: begin
          rs_nxt = rs_r;
        end
      endcase
    end
    sel_nxt = (rs_nxt == RM_FUNC);
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rs_r <= RM_IDLE;
      idx_r <= 6'h0;
      sh_r <= 8'h0;
      od_r <= 1'b0;
      odb_r <= 1'b0;
      odm_r <= 1'b0;
      rc_r <= 1'b0;
      tx_en_r <= 1'b0;
      tx_bit_r <= 1'b0;
      pend_r <= 1'b0;
      sel_r <= 1'b0;
    end else begin
      rs_r <= rs_nxt;
      idx_r <= idx_nxt;
      sh_r <= sh_nxt;
      od_r <= od_nxt;
      odb_r <= odb_nxt;
      odm_r <= odm_nxt;
      rc_r <= rc_nxt;
      tx_en_r <= tx_en_nxt;
      tx_bit_r <= tx_bit_nxt;
      pend_r <= pend_nxt;
      sel_r <= sel_nxt;
    end
  end

  assign selected_o = sel_r;
  assign overdrive_flag_o = od_r;
  assign resume_flag_o = rc_r;

  swr_fifo #(
    .WIDTH(8),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .in_valid_i(pend_r),
    .in_ready_o(f_ready),
    .in_data_i(sh_r),
    .out_valid_o(fn_valid_o),
    .out_ready_i(fn_ready_i),
    .out_data_o(fn_data_o)
  );

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  slot_start_a: assert property (sl_r == SL_IDLE && !bus_in_i
                                 |=> sl_r == SL_LOW && cnt_r == 16'h0)
    else $error("slot timer not started on falling edge");
  read_one_a: assert property (sl_r == SL_IDLE && !bus_in_i && tx_en_r && tx_bit_r
                               |=> !bus_oe_o [*3])
    else $error("line driven in read-one slot");
  read_zero_a: assert property (drv_r && sl_r == SL_LOW |-> cnt_r <= t_rlow + 16'h1)
    else $error("read-zero pulldown outlived slot timer");
  holdoff_a: assert property (sl_r == SL_HOLD && cnt_r < t_hold
                              |=> sl_r != SL_LOW && cnt_r == $past(cnt_r) + 16'h1)
    else $error("glitch inside hold-off started a slot");
  presence_a: assert property (sl_r == SL_PDH && cnt_r == t_pdh |=> bus_oe_o [*2])
    else $error("presence pulse not driven after delay");
  od_clear_a: assert property (rst_r.valid && rst_r.long_pulse |=> !od_r)
    else $error("long reset left overdrive set");
  resume_set_a: assert property ($rose(rc_r) |-> $past(rs_r) inside {RM_MATCH, RM_SDIR})
    else $error("resume flag set outside a selection");
  cmd_len_a: assert property (rs_r == RM_CMD && ev_r.valid && idx_r != LAST_CMD_BIT
                              && !rst_r.valid |=> rs_r == RM_CMD)
    else $error("command left before eight bits");
  skip_a: assert property (rs_r == RM_CMD && ev_r.valid && idx_r == LAST_CMD_BIT
                           && cmd == CMD_SKIP_ROM && !rst_r.valid |=> ##1 selected_o)
    else $error("skip did not select");
  od_skip_a: assert property (rs_r == RM_CMD && ev_r.valid && idx_r == LAST_CMD_BIT
                              && cmd == CMD_OD_SKIP_ROM && !rst_r.valid |=> od_r)
    else $error("overdrive skip did not set overdrive");
  search_cmp_a: assert property (rs_r == RM_SCMP
                                 |-> tx_en_r && tx_bit_r == !ROM_ID[idx_r])
    else $error("search complement bit wrong");

  presence_c: cover property (sl_r == SL_PDL ##1 sl_r == SL_HOLD);
  match_c: cover property (rs_r == RM_MATCH ##1 rs_r == RM_FUNC);
  search_c: cover property (rs_r == RM_SDIR ##1 rs_r == RM_FUNC);
  fifo_full_c: cover property (pend_r && !f_ready);

endmodule // swr_slave

/* File: verif/swr_master_model.sv */
// Behavioural bus master for the single-wire slave.
// Assumes a pulled-up wire; pull_o high means the master pulls it low.
`timescale 1ns/1ps

// ********************************************************************
// Master slot and reset generator
// ********************************************************************
module swr_master_model (
  input wire logic clk_sys_i,
  input wire logic line_i,
  output logic pull_o
);
  logic od;
  initial begin
    od = 1'b0;
    pull_o = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // Low phase, sample, then recovery until the slot ends
  task automatic slot(input int low, input int smp, input int len, output logic v);
    pull_o = 1'b1;
    hold(low);
    pull_o = 1'b0;
    hold(smp - low);
    v = line_i;
    if (od) begin
      // Short glitch inside the rising edge hold-off, or inside the slave pulldown of a read-zero slot
      hold(150 - smp);
      pull_o = 1'b1;
      hold(4);
      pull_o = 1'b0;
      hold(len - 154);
    end else begin
      hold(len - smp);
    end
  endtask

  task automatic wr(input logic b);
    logic v;
    if (b) begin
      slot(od ? 4 : 40, od ? 10 : 100, od ? 200 : 1600, v);
    end else begin
      slot(od ? 130 : 1300, od ? 135 : 1305, od ? 200 : 1600, v);
    end
  endtask

  task automatic rd(output logic v);
    slot(od ? 4 : 40, od ? 60 : 600, od ? 290 : 2100, v);
  endtask

  task automatic wr_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      wr(b[i]);
    end
  endtask

  task automatic bus_reset(input int low, output logic pres);
    pull_o = 1'b1;
    hold(low);
    pull_o = 1'b0;
    hold(od ? 174 : 1252);
    pres = ~line_i;
    hold(od ? 500 : 300);
  endtask
endmodule // swr_master_model

/* File: verif/test_single_wire_slave_rom_layer.sv */
// Self-checking bench for the single-wire slave ROM layer.
// Assumes swr_pkg, swr_slave and swr_master_model are compiled first.
`timescale 1ns/1ps

// ********************************************************************
// Bench top
// ********************************************************************
module test_single_wire_slave_rom_layer;
  import swr_pkg::*;
  localparam logic [63:0] ID = 64'hc3a5_1e0f_77d2_4b19; // Arbitrary value
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic fn_ready = 1'b0;
  logic pull, line, bus_oe, fn_valid, sel, odf, rsf;
  logic [7:0] fn_data;
  int errors = 0;
  int n_checks = 0;

  always #12.5 clk_sys_i = ~clk_sys_i;
  assign line = ~(pull | bus_oe);

  swr_slave #(.ROM_ID(ID), .RST_STD_CYC(4000), .RST_LONG_CYC(4000), .PDL_CYC(100),
    .DEPTH(4)) dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .bus_in_i(line),
    .bus_out_o(), .bus_oe_o(bus_oe), .fn_valid_o(fn_valid), .fn_ready_i(fn_ready),
    .fn_data_o(fn_data), .selected_o(sel), .overdrive_flag_o(odf), .resume_flag_o(rsf));

  swr_master_model mst (.clk_sys_i(clk_sys_i), .line_i(line), .pull_o(pull));

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Overdrive-speed reset, presence expected
  task automatic od_reset;
    logic p;
    mst.bus_reset(2000, p);
    check("od presence", 1, p);
  endtask

  initial begin
    #(25ns * 110000);
    errors++;
    $display("wrong value run time expected done seen hang");
    finish_test();
  end

  initial begin
    logic p, v;
    logic [7:0] d [5];
    int n;
    void'($urandom(55));
    repeat (20) @(posedge clk_sys_i);
    @(negedge clk_sys_i) reset_i = 1'b0;
    mst.bus_reset(4100, p);
    check("presence", 1, p);
    mst.wr_byte(CMD_OD_SKIP_ROM);
    mst.od = 1'b1;
    check("overdrive", 1, odf);
    check("selected", 1, sel);
    // Five function bytes with the consumer stalled
    for (int i = 0; i < 5; i++) begin
      d[i] = 8'($urandom);
      mst.wr_byte(d[i]);
    end
    for (int i = 0; i < 5; i++) begin
      n = 0;
      while (fn_valid !== 1'b1 && n < 20) begin
        @(negedge clk_sys_i);
        n++;
      end
      check("fn valid", 1, fn_valid);
      check("fn byte", d[i], fn_data);
      fn_ready = 1'b1;
      @(negedge clk_sys_i);
      fn_ready = 1'b0;
      @(negedge clk_sys_i);
    end
    @(negedge clk_sys_i);
    check("fifo empty", 0, fn_valid);
    od_reset();
    mst.wr_byte(CMD_READ_ROM);
    for (int i = 0; i < 64; i++) begin
      mst.rd(v);
      check("rom bit", ID[i], v);
    end
    check("overdrive kept", 1, odf);
    od_reset();
    mst.wr_byte(CMD_MATCH_ROM);
    for (int i = 0; i < 64; i++) begin
      mst.wr(ID[i]);
    end
    check("match selected", 1, sel);
    check("resume set", 1, rsf);
    od_reset();
    mst.wr_byte(CMD_RESUME);
    check("resume selected", 1, sel);
    od_reset();
    mst.wr_byte(CMD_OD_MATCH_ROM);
    mst.wr(~ID[0]);
    check("od mismatch sel", 0, sel);
    check("od mismatch speed", 1, odf);
    check("resume cleared", 0, rsf);
    mst.rd(v);
    check("dead silent", 1, v);
    od_reset();
    mst.wr_byte(CMD_RESUME);
    check("resume refused", 0, sel);
    od_reset();
    mst.wr_byte(CMD_SEARCH_ROM);
    for (int i = 0; i < 3; i++) begin
      mst.rd(v);
      check("search true", ID[i], v);
      mst.rd(v);
      check("search comp", !ID[i], v);
      mst.wr(i < 2 ? ID[i] : ~ID[i]);
    end
    mst.rd(v);
    check("search left", 1, v);
    check("search resume", 0, rsf);
    od_reset();
    mst.wr_byte(8'h00);
    mst.rd(v);
    check("unknown cmd", 1, v);
    od_reset();
    mst.wr_byte(CMD_SKIP_ROM);
    check("skip selected", 1, sel);
    mst.od = 1'b0;
    mst.bus_reset(4100, p);
    check("long presence", 1, p);
    check("standard speed", 0, odf);
    finish_test();
  end
endmodule // test_single_wire_slave_rom_layer
